/* shared/sfds_consts.svh */
`ifndef SFDS_CONSTS_SVH
`define SFDS_CONSTS_SVH

// opcodes recognised by the power-mode logic
`define SFDS_OP_SLEEP 8'hb9
`define SFDS_OP_WAKE 8'hab
// bits that make one complete opcode
`define SFDS_OPCODE_BITS 4'h8
// core clock period and documented worst-case transition times
`define SFDS_CLK_PERIOD_NS 40
`define SFDS_SLEEP_ENTRY_DELAY_NS 3000
`define SFDS_SLEEP_EXIT_DELAY_NS 3000
// core cycles from the chip-select edge on the pin to its detection
`define SFDS_SYNC_LATENCY 4
// width of the transition counter
`define SFDS_DELAY_CNT_W 7

`endif

/* shared/sfds_pkg.sv */
`default_nettype none
package sfds_pkg;

  // internal power-mode sequencer states
  typedef enum logic [1:0] {
    SFDS_AWAKE,
    SFDS_ENTER,
    SFDS_SLEEP,
    SFDS_EXIT
  } sfds_state_t;

  // power mode as shown to the rest of the device
  typedef enum logic [2:0] {
    SFDS_PWR_STANDBY,
    SFDS_PWR_ACTIVE,
    SFDS_PWR_ENTERING,
    SFDS_PWR_DEEP_SLEEP,
    SFDS_PWR_LEAVING
  } sfds_pwr_t;

endpackage : sfds_pkg
`default_nettype wire

/* hdl/sfds_link.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sfds_consts.svh"

module sfds_link (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic link_clr,
  input wire logic mosi,
  output logic [7:0] opcode,
  output logic byte_tog
);

  logic [3:0] bit_cnt;
  logic [6:0] shift;
  logic frame_clr;

  // chip select high ends the frame even though sck has stopped
  assign frame_clr = cs_n | link_clr;

  // shift in msb first; count stops at a full byte so trailing bits are dropped
  always_ff @(posedge sck or posedge frame_clr) begin
    if (frame_clr) begin
      bit_cnt <= 4'h0;
      shift <= 7'h00;
    end else if (bit_cnt != `SFDS_OPCODE_BITS) begin
      bit_cnt <= bit_cnt + 4'h1;
      shift <= {shift[5:0], mosi};
    end
  end

  // opcode is held across frames; the toggle tells the core a byte landed
  always_ff @(posedge sck or posedge link_clr) begin
    if (link_clr) begin
      opcode <= 8'h00;
      byte_tog <= 1'b0;
    end else if (!cs_n && bit_cnt == `SFDS_OPCODE_BITS - 4'h1) begin
      opcode <= {shift, mosi};
      byte_tog <= ~byte_tog;
    end
  end

endmodule : sfds_link
`default_nettype wire

/* hdl/sfds_top.sv */
// Behaviour
// - standby when deselected and not busy
// - in deep sleep ignore all but resume
// - power-down opcode acted on at deselect
// - bits after the opcode byte are ignored
// - deep sleep reached within entry delay
// - short power-down opcode aborts, stays standby
// - reset always starts in standby
// - power-down ignored while program or erase busy
// - resume opcode only command in deep sleep
// - standby reached within exit delay
// - short resume opcode aborts, stays asleep
// - busy status bit reports program or erase
`timescale 1ns/100ps
`default_nettype none
`include "sfds_consts.svh"

module sfds_top
  import sfds_pkg::*;
#(
  parameter int ENTRY_NS = `SFDS_SLEEP_ENTRY_DELAY_NS,
  parameter int EXIT_NS = `SFDS_SLEEP_EXIT_DELAY_NS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic op_busy,
  output logic deep_sleep,
  output logic standby,
  output logic operation_in_progress_flag,
  output logic frame_active,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic sleep_refused,
  output sfds_pwr_t power_state
);

  // longest times round down, then the synchroniser delay is taken off
  // so the whole path from the pin edge stays inside the documented bound
  localparam int ENTRY_CYC_RAW = ENTRY_NS / `SFDS_CLK_PERIOD_NS - `SFDS_SYNC_LATENCY;
  localparam int EXIT_CYC_RAW = EXIT_NS / `SFDS_CLK_PERIOD_NS - `SFDS_SYNC_LATENCY;
  localparam int ENTRY_CYC = (ENTRY_CYC_RAW < 1) ? 1 : ENTRY_CYC_RAW;
  localparam int EXIT_CYC = (EXIT_CYC_RAW < 1) ? 1 : EXIT_CYC_RAW;
  localparam logic [`SFDS_DELAY_CNT_W-1:0] ENTRY_LOAD = ENTRY_CYC[`SFDS_DELAY_CNT_W-1:0];
  localparam logic [`SFDS_DELAY_CNT_W-1:0] EXIT_LOAD = EXIT_CYC[`SFDS_DELAY_CNT_W-1:0];

  logic link_clr;
  logic [7:0] link_opcode;
  logic link_tog;

  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  logic cs_rise;
  logic cs_fall;
  logic tog_edge;

  logic rx_valid;
  logic [7:0] rx_opcode;
  logic frame_ok;
  logic [7:0] frame_op;
  logic is_sleep_op;
  logic is_wake_op;

  sfds_state_t state;
  sfds_state_t next_state;
  logic [`SFDS_DELAY_CNT_W-1:0] delay_cnt;
  logic [`SFDS_DELAY_CNT_W-1:0] next_delay_cnt;
  logic delay_done;
  logic accept_sleep;
  logic refuse_sleep;
  logic accept_wake;
  logic forward_cmd;

  // hold the link side cleared while the core is in reset; the link clock
  // is quiet outside frames so releasing it asynchronously is harmless
  always_ff @(posedge clk) begin
    if (!rstn) begin
      link_clr <= 1'b1;
    end else begin
      link_clr <= 1'b0;
    end
  end

  // serial side on the host's clock
  sfds_link u_link (
    .sck(sck),
    .cs_n(cs_n),
    .link_clr(link_clr),
    .mosi(mosi),
    .opcode(link_opcode),
    .byte_tog(link_tog)
  );

  // chip select crosses as a level; third stage only feeds edge detection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
    end
  end

  // byte-complete event crosses as a toggle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end else begin
      tog_s1 <= link_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  assign cs_rise = cs_s2 & ~cs_s3;
  assign cs_fall = ~cs_s2 & cs_s3;
  assign tog_edge = tog_s2 ^ tog_s3;

  // the link opcode is stable from the toggle until the next frame's
  // eighth bit, far longer than the synchroniser delay, so it is safe here
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_opcode <= 8'h00;
    end else if (tog_edge) begin
      rx_opcode <= link_opcode;
    end
  end

  // a captured byte belongs to one frame only; a new select starts empty
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_valid <= 1'b0;
    end else if (cs_rise || cs_fall) begin
      rx_valid <= 1'b0;
    end else if (tog_edge) begin
      rx_valid <= 1'b1;
    end
  end

  // toggle and deselect may land in the same cycle; the byte still counts
  assign frame_ok = rx_valid | tog_edge;
  assign frame_op = tog_edge ? link_opcode : rx_opcode;
  assign is_sleep_op = frame_ok && frame_op == `SFDS_OP_SLEEP;
  assign is_wake_op = frame_ok && frame_op == `SFDS_OP_WAKE;

  // decisions are all taken at deselect, never mid-frame
  assign accept_sleep = cs_rise && is_sleep_op && !op_busy && state == SFDS_AWAKE;
  assign refuse_sleep = cs_rise && is_sleep_op && op_busy && state == SFDS_AWAKE;
  assign accept_wake = cs_rise && is_wake_op && state == SFDS_SLEEP;
  // other complete commands go to the rest of the device only when awake
  assign forward_cmd = cs_rise && frame_ok && !is_sleep_op && state == SFDS_AWAKE;
  assign delay_done = delay_cnt == {`SFDS_DELAY_CNT_W{1'b0}};

  // power-mode sequencer next state
  always_comb begin
    next_state = state;
    next_delay_cnt = delay_cnt;
    case (state)
      SFDS_AWAKE: begin
        // a short or foreign frame leaves the device awake
        if (accept_sleep) begin
          next_state = SFDS_ENTER;
          next_delay_cnt = ENTRY_LOAD - 1'b1;
        end
      end
      SFDS_ENTER: begin
        // frames during the entry window are dropped
        if (delay_done) begin
          next_state = SFDS_SLEEP;
        end else begin
          next_delay_cnt = delay_cnt - 1'b1;
        end
      end
      SFDS_SLEEP: begin
        // only a full resume opcode wakes; anything else is ignored
        if (accept_wake) begin
          next_state = SFDS_EXIT;
          next_delay_cnt = EXIT_LOAD - 1'b1;
        end
      end
      SFDS_EXIT: begin
        if (delay_done) begin
          next_state = SFDS_AWAKE;
        end else begin
          next_delay_cnt = delay_cnt - 1'b1;
        end
      end
      default: begin
        next_state = SFDS_AWAKE;
        next_delay_cnt = {`SFDS_DELAY_CNT_W{1'b0}};
      end
    endcase
  end

  // reset always lands awake, never in deep sleep
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= SFDS_AWAKE;
    end else begin
      state <= next_state;
    end
  end

  // transition timer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      delay_cnt <= {`SFDS_DELAY_CNT_W{1'b0}};
    end else begin
      delay_cnt <= next_delay_cnt;
    end
  end

  // deep sleep indicator; stays high through the exit window, since the
  // device is only usable again once it is back in standby
  always_ff @(posedge clk) begin
    if (!rstn) begin
      deep_sleep <= 1'b0;
    end else begin
      deep_sleep <= next_state == SFDS_SLEEP || next_state == SFDS_EXIT;
    end
  end

  // standby: awake, deselected and no self-timed operation running
  always_ff @(posedge clk) begin
    if (!rstn) begin
      standby <= 1'b1;
    end else begin
      standby <= next_state == SFDS_AWAKE && cs_s2 && !op_busy;
    end
  end

  // busy status bit mirrors the program or erase engine
  always_ff @(posedge clk) begin
    if (!rstn) begin
      operation_in_progress_flag <= 1'b0;
    end else begin
      operation_in_progress_flag <= op_busy;
    end
  end

  // selection seen by the rest of the device; masked while asleep so
  // no status read or other command can start there
  always_ff @(posedge clk) begin
    if (!rstn) begin
      frame_active <= 1'b0;
    end else begin
      frame_active <= !cs_s2 && next_state == SFDS_AWAKE;
    end
  end

  // one-cycle command strobe with its opcode
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= forward_cmd;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmd_opcode <= 8'h00;
    end else if (forward_cmd) begin
      cmd_opcode <= frame_op;
    end
  end

  // refused power-down is reported so firmware knows to send it again
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sleep_refused <= 1'b0;
    end else begin
      sleep_refused <= refuse_sleep;
    end
  end

  // summary of the power mode
  always_ff @(posedge clk) begin
    if (!rstn) begin
      power_state <= SFDS_PWR_STANDBY;
    end else begin
      case (next_state)
        SFDS_AWAKE: begin
          if (cs_s2 && !op_busy) begin
            power_state <= SFDS_PWR_STANDBY;
          end else begin
            power_state <= SFDS_PWR_ACTIVE;
          end
        end
        SFDS_ENTER: begin
          power_state <= SFDS_PWR_ENTERING;
        end
        SFDS_SLEEP: begin
          power_state <= SFDS_PWR_DEEP_SLEEP;
        end
        SFDS_EXIT: begin
          power_state <= SFDS_PWR_LEAVING;
        end
        default: begin
          power_state <= SFDS_PWR_STANDBY;
        end
      endcase
    end
  end

endmodule : sfds_top
`default_nettype wire

/* tb/sfds_top_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module sfds_top_asserts
  import sfds_pkg::*;
#(
  parameter int ENTRY_NS = 3000,
  parameter int EXIT_NS = 3000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic op_busy,
  input wire logic deep_sleep,
  input wire logic standby,
  input wire logic frame_active,
  input wire logic operation_in_progress_flag,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic sleep_refused,
  input wire sfds_pwr_t power_state
);
  // worst-case transition windows in core cycles
  localparam int ENT_MAX = ENTRY_NS / 40;
  localparam int EXT_MAX = EXIT_NS / 40;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_std;
    standby |-> !deep_sleep && !operation_in_progress_flag;
  endproperty
  a_std: assert property (p_std) else $error("standby while busy or asleep");
  property p_flag;
    $past(rstn) |-> operation_in_progress_flag == $past(op_busy);
  endproperty
  a_flag: assert property (p_flag) else $error("busy flag wrong");
  property p_quiet;
    deep_sleep |-> !cmd_valid && !sleep_refused;
  endproperty
  a_quiet: assert property (p_quiet) else $error("command accepted asleep");
  property p_mask;
    deep_sleep |-> !frame_active;
  endproperty
  a_mask: assert property (p_mask) else $error("selection seen while asleep");
  property p_entry;
    $rose(power_state == SFDS_PWR_ENTERING) |-> ##[1:ENT_MAX] deep_sleep;
  endproperty
  a_entry: assert property (p_entry) else $error("entry too slow");
  property p_exit;
    $rose(power_state == SFDS_PWR_LEAVING) |-> ##[1:EXT_MAX] !deep_sleep;
  endproperty
  a_exit: assert property (p_exit) else $error("exit too slow");
  property p_via;
    $rose(deep_sleep) |-> $past(power_state) == SFDS_PWR_ENTERING;
  endproperty
  a_via: assert property (p_via) else $error("sleep without entry");
  property p_refuse;
    sleep_refused |=> !sleep_refused && power_state != SFDS_PWR_ENTERING;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused entry proceeded");
  property p_pulse;
    cmd_valid |=> !cmd_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("command pulse too long");
  property p_hold;
    !cmd_valid |-> $stable(cmd_opcode);
  endproperty
  a_hold: assert property (p_hold) else $error("opcode changed without pulse");
  property p_rst;
    $rose(rstn) |-> power_state == SFDS_PWR_STANDBY && !deep_sleep;
  endproperty
  a_rst: assert property (p_rst) else $error("not standby after reset");
  c_enter: cover property ($rose(deep_sleep));
  c_leave: cover property ($fell(deep_sleep));
  c_ref: cover property (sleep_refused);
endmodule : sfds_top_asserts
bind sfds_top sfds_top_asserts #(.ENTRY_NS(ENTRY_NS), .EXIT_NS(EXIT_NS)) u_chk (
  .clk(clk), .rstn(rstn), .op_busy(op_busy), .deep_sleep(deep_sleep), .standby(standby),
  .operation_in_progress_flag(operation_in_progress_flag), .cmd_valid(cmd_valid),
  .cmd_opcode(cmd_opcode), .sleep_refused(sleep_refused), .frame_active(frame_active),
  .power_state(power_state));
`default_nettype wire

/* tb/sfds_host.sv */
`timescale 1ns/100ps
`default_nettype none
module sfds_host (
  output logic sck,
  output logic cs_n,
  output logic mosi
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // one framed transfer, msb first; sck stands still outside frames
  task send(input logic [15:0] d, input int n);
    #7 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = d[15 - i];
      #20 sck = 1'b1;
      #40 sck = 1'b0;
      #20;
    end
    #30 cs_n = 1'b1;
    mosi = ~mosi; // released line must not look held
    #150;
  endtask : send
endmodule : sfds_host
`default_nettype wire

/* tb/tb_sfds_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_sfds_top;
  import sfds_pkg::*;
  localparam int ENT = 400;
  localparam int WT = ENT / 40 + 3;
  typedef struct {logic [15:0] d; int n; logic bz; int cv;
    logic [7:0] op; int rf; logic ds;} sfds_row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic op_busy = 1'b0;
  wire sck, cs_n, mosi;
  logic deep_sleep, standby, flag, frame_active, cmd_valid, sleep_refused;
  logic [7:0] cmd_opcode;
  sfds_pwr_t power_state;
  int fail_count = 0;
  int cmp_count = 0;
  int n_cmd = 0;
  int n_ref = 0;
  int n_act = 0;
  int b_cmd, b_ref, b_act;
  sfds_row_t rows [6];
  sfds_top #(.ENTRY_NS(ENT), .EXIT_NS(ENT)) DUT (.clk(clk), .rstn(rstn), .sck(sck),
    .cs_n(cs_n), .mosi(mosi), .op_busy(op_busy), .deep_sleep(deep_sleep), .standby(standby),
    .operation_in_progress_flag(flag), .frame_active(frame_active), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .sleep_refused(sleep_refused), .power_state(power_state));
  sfds_host host (.sck(sck), .cs_n(cs_n), .mosi(mosi));
  always #20 clk = ~clk;
  // pulse counters, so one-cycle strobes are never missed
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) n_cmd++;
    if (sleep_refused === 1'b1) n_ref++;
    if (frame_active === 1'b1) n_act++;
  end
  task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // one frame, then enough core cycles for the worst-case transition
  task frame(input logic [15:0] d, input int n);
    @(posedge clk);
    #1 b_cmd = n_cmd;
    b_ref = n_ref;
    b_act = n_act;
    host.send(d, n);
    repeat (WT) @(posedge clk);
    #1;
  endtask : frame
  task final_report;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  initial begin
    #200000 fail_count++;
    final_report();
  end
  initial begin
    rows[0] = '{16'hab00, 8, 1'b0, 1, 8'hab, 0, 1'b0};
    rows[1] = '{16'h9f00, 8, 1'b0, 1, 8'h9f, 0, 1'b0};
    rows[2] = '{16'hb900, 5, 1'b0, 0, 8'h9f, 0, 1'b0};
    rows[3] = '{16'hb900, 7, 1'b0, 0, 8'h9f, 0, 1'b0};
    rows[4] = '{16'hb900, 8, 1'b1, 0, 8'h9f, 1, 1'b0};
    rows[5] = '{16'hb95a, 16, 1'b0, 0, 8'h9f, 0, 1'b1};
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    check("standby", standby, 8'h01);
    // let the link clear drop before the first select
    @(posedge clk);
    foreach (rows[i]) begin
      op_busy = rows[i].bz;
      frame(rows[i].d, rows[i].n);
      check("cmds", 8'(n_cmd - b_cmd), 8'(rows[i].cv));
      check("opcode", cmd_opcode, rows[i].op);
      check("refused", 8'(n_ref - b_ref), 8'(rows[i].rf));
      check("sleep", deep_sleep, rows[i].ds);
      check("standby", standby, !rows[i].ds && !rows[i].bz);
      check("flag", flag, rows[i].bz);
      check("active", 8'(n_act != b_act), 8'h01);
      op_busy = 1'b0;
    end
    frame(16'h9f00, 8);
    check("cmds", 8'(n_cmd - b_cmd), 8'h00);
    check("sleep", deep_sleep, 8'h01);
    check("active", 8'(n_act != b_act), 8'h00);
    frame(16'hab00, 5);
    check("sleep", deep_sleep, 8'h01);
    frame(16'habff, 12);
    check("sleep", deep_sleep, 8'h00);
    check("standby", standby, 8'h01);
    check("cmds", 8'(n_cmd - b_cmd), 8'h00);
    check("active", 8'(n_act != b_act), 8'h00);
    op_busy = 1'b1;
    frame(16'hb900, 8);
    check("refused", 8'(n_ref - b_ref), 8'h01);
    op_busy = 1'b0;
    frame(16'hb900, 8);
    check("sleep", deep_sleep, 8'h01);
    rstn = 1'b0;
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    check("sleep", deep_sleep, 8'h00);
    check("state", 8'(power_state), 8'(SFDS_PWR_STANDBY));
    @(posedge clk);
    frame(16'h9f00, 8);
    check("cmds", 8'(n_cmd - b_cmd), 8'h01);
    final_report();
  end
endmodule : tb_sfds_top
`default_nettype wire
